/* File: src/udrt_pkg.sv */
package udrt_pkg;
	localparam int UDRT_ADDR_W = 18;
	localparam int UDRT_PRESC_W = 13;
	// Register indices; the byte address is four times the index
	localparam logic [15:0] UDRT_IDX_MODE = 16'hffb4;
	localparam logic [15:0] UDRT_IDX_COUNT = 16'hffb5;
	localparam logic [15:0] UDRT_IDX_CLKSTOP = 16'hfffa;
	localparam logic [15:0] UDRT_IDX_IRQ_STATUS = 16'hffc0;
	localparam logic [15:0] UDRT_IDX_IRQ_CLEAR = 16'hffc1;
	localparam logic [15:0] UDRT_IDX_IRQ_ENABLE = 16'hffc2;
	// Field positions
	localparam int UDRT_STANDBY_BIT = 1;
	localparam int UDRT_WRAP_BIT = 0;
	// Reset values, reserved mode field value and count limits
	localparam logic [7:0] UDRT_MODE_RST = 8'h18;
	localparam logic [7:0] UDRT_COUNT_RST = 8'h00;
	localparam logic [7:0] UDRT_RELOAD_RST = 8'h00;
	localparam logic [7:0] UDRT_CLKSTOP_RST = 8'hff;
	localparam logic [1:0] UDRT_RSVD_VAL = 2'h3;
	localparam logic [7:0] UDRT_COUNT_MAX = 8'hff;
	localparam logic [7:0] UDRT_COUNT_MIN = 8'h00;
	// Prescaler tap widths: system clock divided by 2**width
	localparam int UDRT_TAP_8192 = 13;
	localparam int UDRT_TAP_2048 = 11;
	localparam int UDRT_TAP_512 = 9;
	localparam int UDRT_TAP_64 = 6;
	localparam int UDRT_TAP_16 = 4;
	localparam int UDRT_TAP_4 = 2;

	typedef enum logic [2:0] {
		UDRT_CLK_8192,
		UDRT_CLK_2048,
		UDRT_CLK_512,
		UDRT_CLK_64,
		UDRT_CLK_16,
		UDRT_CLK_4,
		UDRT_CLK_SUB4,
		UDRT_CLK_EVENT
	} udrt_clk_sel_t;

	typedef struct packed {
		logic reload_mode_sel;
		logic hw_direction_sel;
		logic sw_direction_sel;
		logic [1:0] rsvd;
		udrt_clk_sel_t count_clock_sel;
	} udrt_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [UDRT_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} udrt_apb_req_t;
endpackage

/* File: src/udrt_timer.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module udrt_timer
	import udrt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [UDRT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_input_pin,
	input wire logic direction_input_pin,
	input wire logic subclk_div4,
	input wire logic event_edge_sel,
	input wire logic sub_mode,
	input wire logic halt_mode,
	output logic irq
);
	udrt_apb_req_t req;
	udrt_mode_t mode_reg;
	logic [7:0] count_reg;
	logic [7:0] reload_reg;
	logic [7:0] clkstop_reg;
	logic [7:0] status_reg;
	logic [7:0] enable_reg;
	logic [UDRT_PRESC_W-1:0] presc_reg;
	logic ev_meta_reg, ev_sync_reg, ev_prev_reg;
	logic sub_meta_reg, sub_sync_reg, sub_prev_reg;
	logic dir_meta_reg, dir_sync_reg;
	logic [7:0] rd_data;
	logic rd_hit;
	logic access;
	logic wr_go;
	logic wr_mode, wr_count, wr_clkstop, wr_clear, wr_enable;
	logic ev_edge, sub_edge;
	logic tap_tick;
	logic tick;
	logic count_down;
	logic wrap;
	logic [7:0] count_next;
	logic [7:0] status_next;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// Two-cycle access phase keeps pready registered
	assign access = req.psel && req.penable && pready;
	assign wr_go = access && req.pwrite;
	assign wr_mode = wr_go && req.paddr == {UDRT_IDX_MODE, 2'h0};
	assign wr_count = wr_go && req.paddr == {UDRT_IDX_COUNT, 2'h0};
	assign wr_clkstop = wr_go && req.paddr == {UDRT_IDX_CLKSTOP, 2'h0};
	assign wr_clear = wr_go && req.paddr == {UDRT_IDX_IRQ_CLEAR, 2'h0};
	assign wr_enable = wr_go && req.paddr == {UDRT_IDX_IRQ_ENABLE, 2'h0};

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 8'h00;
		unique case (req.paddr)
			{UDRT_IDX_MODE, 2'h0}: rd_data = mode_reg;
			{UDRT_IDX_COUNT, 2'h0}: rd_data = count_reg;
			{UDRT_IDX_CLKSTOP, 2'h0}: rd_data = clkstop_reg;
			{UDRT_IDX_IRQ_STATUS, 2'h0}: rd_data = status_reg;
			{UDRT_IDX_IRQ_ENABLE, 2'h0}: rd_data = enable_reg;
			{UDRT_IDX_IRQ_CLEAR, 2'h0}: rd_data = 8'h00;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (pclken) begin
			pready <= req.psel && req.penable && !pready;
			// Error stands only beside its pready pulse
			pslverr <= req.psel && req.penable && !pready && !rd_hit;
			if (req.psel && req.penable && !pready) begin
				prdata <= req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_data};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= UDRT_MODE_RST;
		end else if (pclken && wr_mode) begin
			mode_reg <= {req.pwdata[7:5], UDRT_RSVD_VAL, req.pwdata[2:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkstop_reg <= UDRT_CLKSTOP_RST;
		end else if (pclken && wr_clkstop) begin
			clkstop_reg <= req.pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_reg <= UDRT_RELOAD_RST;
		end else if (pclken && wr_count) begin
			reload_reg <= req.pwdata[7:0];
		end
	end

	// Synchronizers; first stages feed only second stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_meta_reg <= 1'b0;
			ev_sync_reg <= 1'b0;
			ev_prev_reg <= 1'b0;
			sub_meta_reg <= 1'b0;
			sub_sync_reg <= 1'b0;
			sub_prev_reg <= 1'b0;
			dir_meta_reg <= 1'b0;
			dir_sync_reg <= 1'b0;
		end else if (pclken) begin
			ev_meta_reg <= event_input_pin;
			ev_sync_reg <= ev_meta_reg;
			ev_prev_reg <= ev_sync_reg;
			sub_meta_reg <= subclk_div4;
			sub_sync_reg <= sub_meta_reg;
			sub_prev_reg <= sub_sync_reg;
			dir_meta_reg <= direction_input_pin;
			dir_sync_reg <= dir_meta_reg;
		end
	end

	// Edge select high counts rising edges
	assign ev_edge = event_edge_sel ? (ev_sync_reg && !ev_prev_reg) : (!ev_sync_reg && ev_prev_reg);
	assign sub_edge = sub_sync_reg && !sub_prev_reg;

	// Free-running prescaler; taps fire when their low bits are all ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= '0;
		end else if (pclken) begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	always_comb begin
		tap_tick = 1'b0;
		unique case (mode_reg.count_clock_sel)
			UDRT_CLK_8192: tap_tick = &presc_reg[UDRT_TAP_8192-1:0];
			UDRT_CLK_2048: tap_tick = &presc_reg[UDRT_TAP_2048-1:0];
			UDRT_CLK_512: tap_tick = &presc_reg[UDRT_TAP_512-1:0];
			UDRT_CLK_64: tap_tick = &presc_reg[UDRT_TAP_64-1:0];
			UDRT_CLK_16: tap_tick = &presc_reg[UDRT_TAP_16-1:0];
			UDRT_CLK_4: tap_tick = &presc_reg[UDRT_TAP_4-1:0];
			UDRT_CLK_SUB4: tap_tick = sub_edge;
			UDRT_CLK_EVENT: tap_tick = ev_edge;
		endcase
	end

	// Sub modes stop the system-clock taps; standby and halt stop everything
	assign tick = tap_tick && clkstop_reg[UDRT_STANDBY_BIT] && !halt_mode
		&& (!sub_mode || mode_reg.count_clock_sel == UDRT_CLK_SUB4
		|| mode_reg.count_clock_sel == UDRT_CLK_EVENT);
	assign count_down = mode_reg.hw_direction_sel ? dir_sync_reg : mode_reg.sw_direction_sel;
	assign wrap = tick && (count_down ? count_reg == UDRT_COUNT_MIN : count_reg == UDRT_COUNT_MAX);

	always_comb begin
		count_next = count_reg;
		if (wr_count) begin
			count_next = req.pwdata[7:0];
		end else if (wrap && mode_reg.reload_mode_sel) begin
			count_next = reload_reg;
		end else if (wrap) begin
			count_next = count_down ? UDRT_COUNT_MAX : UDRT_COUNT_MIN;
		end else if (tick) begin
			count_next = count_down ? count_reg - 1'b1 : count_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= UDRT_COUNT_RST;
		end else if (pclken) begin
			count_reg <= count_next;
		end
	end

	// Wrap event beats a same-cycle clear
	always_comb begin
		status_next = status_reg;
		if (wr_clear) begin
			status_next = status_reg & ~req.pwdata[7:0];
		end
		if (wrap) begin
			status_next[UDRT_WRAP_BIT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 8'h00;
			enable_reg <= 8'h00;
			irq <= 1'b0;
		end else if (pclken) begin
			status_reg <= status_next;
			if (wr_enable) begin
				enable_reg <= req.pwdata[7:0];
			end
			irq <= |(status_reg & enable_reg);
		end
	end

	sequence count_write_s;
		pclken && wr_count;
	endsequence

	sequence clean_tick_s;
		pclken && tick && !wr_count;
	endsequence

	property p_load_copy;
		@(posedge pclk) disable iff (!presetn)
		count_write_s |=> count_reg == $past(req.pwdata[7:0]) && reload_reg == $past(req.pwdata[7:0]);
	endproperty

	load_copy_a: assert property (p_load_copy) else $error("reload write did not load counter");

	reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && req.psel && req.penable && !pready && !req.pwrite && req.paddr == {UDRT_IDX_MODE, 2'h0}
		|=> prdata[4:3] == UDRT_RSVD_VAL) else $error("reserved mode bits not read as one");

	wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && wrap |=> status_reg[UDRT_WRAP_BIT]) else $error("wrap did not set flag");

	irq_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && status_reg[UDRT_WRAP_BIT] && enable_reg[UDRT_WRAP_BIT] |=> irq) else $error("irq missing");

	interval_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		clean_tick_s ##0 (!mode_reg.reload_mode_sel && !count_down && count_reg == UDRT_COUNT_MAX)
		|=> count_reg == UDRT_COUNT_MIN) else $error("interval overflow did not wrap to zero");

	reload_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		clean_tick_s ##0 (mode_reg.reload_mode_sel && wrap)
		|=> count_reg == $past(reload_reg)) else $error("auto reload missed");

	hw_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		clean_tick_s ##0 (mode_reg.hw_direction_sel && dir_sync_reg && count_reg != UDRT_COUNT_MIN)
		|=> count_reg == $past(count_reg) - 8'h01) else $error("pin high did not count down");

	standby_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clkstop_reg[UDRT_STANDBY_BIT] && !wr_count |=> $stable(count_reg)) else $error("counted in standby");

	sub_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		sub_mode && mode_reg.count_clock_sel < UDRT_CLK_SUB4 && !wr_count
		|=> $stable(count_reg)) else $error("counted on system tap in sub mode");

	event_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode_reg.count_clock_sel == UDRT_CLK_EVENT && !ev_edge && !wr_count
		|=> $stable(count_reg)) else $error("counted without event edge");

	sequence step_tick_s;
		pclken && tick && !wr_count && !wrap;
	endsequence

	mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && wr_mode
		|=> mode_reg.reload_mode_sel == $past(req.pwdata[7]) && mode_reg.hw_direction_sel == $past(req.pwdata[6]))
		else $error("mode write did not land");

	sw_dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && wr_mode
		|=> mode_reg.sw_direction_sel == $past(req.pwdata[5]) && mode_reg.count_clock_sel == $past(req.pwdata[2:0]))
		else $error("direction or clock select write did not land");

	rsvd_const_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> mode_reg.rsvd == UDRT_RSVD_VAL)
		else $error("reserved mode bits changed");

	sw_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_tick_s ##0 (!mode_reg.hw_direction_sel && !mode_reg.sw_direction_sel)
		|=> count_reg == $past(count_reg) + 8'h01)
		else $error("software up count wrong");

	sw_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_tick_s ##0 (!mode_reg.hw_direction_sel && mode_reg.sw_direction_sel)
		|=> count_reg == $past(count_reg) - 8'h01)
		else $error("software down count wrong");

	hw_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_tick_s ##0 (mode_reg.hw_direction_sel && !dir_sync_reg)
		|=> count_reg == $past(count_reg) + 8'h01)
		else $error("pin low did not count up");

	underflow_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		clean_tick_s ##0 (!mode_reg.reload_mode_sel && count_down && count_reg == UDRT_COUNT_MIN)
		|=> count_reg == UDRT_COUNT_MAX)
		else $error("interval underflow did not wrap to ff");

	tap4_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && tick && mode_reg.count_clock_sel == UDRT_CLK_4
		|=> (!tick || mode_reg.count_clock_sel != UDRT_CLK_4) [*3])
		else $error("divide by four tap too fast");

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && wr_clear && req.pwdata[UDRT_WRAP_BIT] && !wrap
		|=> !status_reg[UDRT_WRAP_BIT])
		else $error("flag clear ignored");

	flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		status_reg[UDRT_WRAP_BIT] && !wr_clear
		|=> status_reg[UDRT_WRAP_BIT])
		else $error("flag dropped without clear");

	irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && (status_reg & enable_reg) == 8'h00
		|=> !irq)
		else $error("irq without enabled flag");

	count_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && req.psel && req.penable && !pready && !req.pwrite && req.paddr == {UDRT_IDX_COUNT, 2'h0}
		|=> prdata[7:0] == $past(count_reg))
		else $error("count read wrong");

	write_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && req.psel && req.penable && !pready && req.pwrite
		|=> prdata == 32'h0000_0000)
		else $error("write returned data");

	reload_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && !wr_count
		|=> $stable(reload_reg))
		else $error("reload value changed without write");

	event_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && ev_edge && mode_reg.count_clock_sel == UDRT_CLK_EVENT && clkstop_reg[UDRT_STANDBY_BIT]
		&& !halt_mode && !wr_count && !wrap |=> !$stable(count_reg))
		else $error("event edge not counted");

	sub_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && sub_edge && mode_reg.count_clock_sel == UDRT_CLK_SUB4 && clkstop_reg[UDRT_STANDBY_BIT]
		&& !halt_mode && !wr_count && !wrap |=> !$stable(count_reg))
		else $error("subclock edge not counted");

	halt_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode && !wr_count
		|=> $stable(count_reg))
		else $error("counted while halted");

	edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclken && ev_edge
		|=> !ev_edge)
		else $error("event edge seen twice");

	// Error flag is only meaningful beside pready
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr
		|-> pready)
		else $error("error without ready");
endmodule // udrt_timer

/* File: verif/udrt_pins_model.sv */
`timescale 1ns/10ps
module udrt_pins_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pulse_go,
	input wire logic dir_req,
	output logic event_input_pin,
	output logic direction_input_pin
);
	logic [2:0] hold_reg;
	// Pulse held five cycles so the two-stage synchronizer sees both edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_reg <= 3'h0;
			event_input_pin <= 1'b0;
		end else if (pulse_go) begin
			hold_reg <= 3'h5;
			event_input_pin <= 1'b1;
		end else if (hold_reg != 3'h0) begin
			hold_reg <= hold_reg - 3'h1;
			event_input_pin <= (hold_reg != 3'h1);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			direction_input_pin <= 1'b0;
		else
			direction_input_pin <= dir_req;
	end
endmodule // udrt_pins_model

/* File: verif/udrt_timer_tb.sv */
`timescale 1ns/10ps
module udrt_timer_tb;
	import udrt_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic subclk_div4 = 0, event_edge_sel = 1, ev_go = 0, dir_req = 0;
	logic sub_mode = 0, halt_mode = 0;
	logic [UDRT_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, ev_pin, dir_pin, er;
	logic [7:0] rd;
	int n_mismatch = 0, checks = 0;
	always #5 pclk = ~pclk;
	udrt_pins_model pins (.pclk(pclk), .presetn(presetn), .pulse_go(ev_go), .dir_req(dir_req),
		.event_input_pin(ev_pin), .direction_input_pin(dir_pin));
	udrt_timer dut (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_input_pin(ev_pin), .direction_input_pin(dir_pin),
		.subclk_div4(subclk_div4), .event_edge_sel(event_edge_sel), .sub_mode(sub_mode),
		.halt_mode(halt_mode), .irq(irq));
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata[7:0];
		er = pslverr;
		if (n >= 64)
			n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		cmp8(rd, exp);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			ev_go <= 1'b1;
			@(posedge pclk);
			ev_go <= 1'b0;
			repeat (14) @(posedge pclk);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(UDRT_IDX_MODE, 8'h18);
		rdc(UDRT_IDX_COUNT, 8'h00);
		rdc(UDRT_IDX_CLKSTOP, 8'hff);
		cmp1(irq, 1'b0);
		apb(1'b1, UDRT_IDX_MODE, 8'h00);
		rdc(UDRT_IDX_MODE, 8'h18);
		apb(1'b1, UDRT_IDX_IRQ_ENABLE, 8'h01);
		// Pin routed to events here, with the wrap interrupt already enabled
		apb(1'b1, UDRT_IDX_MODE, 8'h07);
		for (int e = 1; e >= 0; e--) begin
			event_edge_sel <= e[0];
			apb(1'b1, UDRT_IDX_COUNT, 8'hfe);
			rdc(UDRT_IDX_COUNT, 8'hfe);
			pulse(1);
			rdc(UDRT_IDX_COUNT, 8'hff);
			pulse(1);
			rdc(UDRT_IDX_COUNT, 8'h00);
			rdc(UDRT_IDX_IRQ_STATUS, 8'h01);
			cmp1(irq, 1'b1);
			apb(1'b1, UDRT_IDX_IRQ_CLEAR, 8'h01);
			rdc(UDRT_IDX_IRQ_STATUS, 8'h00);
			cmp1(irq, 1'b0);
		end
		apb(1'b1, UDRT_IDX_MODE, 8'h27);
		apb(1'b1, UDRT_IDX_COUNT, 8'h00);
		pulse(2);
		rdc(UDRT_IDX_COUNT, 8'hfe);
		apb(1'b1, UDRT_IDX_IRQ_ENABLE, 8'h00);
		apb(1'b1, UDRT_IDX_MODE, 8'h87);
		rdc(UDRT_IDX_MODE, 8'h9f);
		apb(1'b1, UDRT_IDX_COUNT, 8'hfe);
		pulse(2);
		rdc(UDRT_IDX_COUNT, 8'hfe);
		rdc(UDRT_IDX_IRQ_STATUS, 8'h01);
		cmp1(irq, 1'b0);
		apb(1'b1, UDRT_IDX_IRQ_CLEAR, 8'h01);
		dir_req <= 1'b1;
		apb(1'b1, UDRT_IDX_MODE, 8'h67);
		apb(1'b1, UDRT_IDX_COUNT, 8'h10);
		pulse(1);
		rdc(UDRT_IDX_COUNT, 8'h0f);
		dir_req <= 1'b0;
		pulse(1);
		rdc(UDRT_IDX_COUNT, 8'h10);
		apb(1'b1, UDRT_IDX_MODE, 8'h06);
		apb(1'b1, UDRT_IDX_COUNT, 8'h20);
		subclk_div4 <= 1'b1;
		repeat (8) @(posedge pclk);
		subclk_div4 <= 1'b0;
		repeat (8) @(posedge pclk);
		rdc(UDRT_IDX_COUNT, 8'h21);
		// Prescaler phase is free running, so allow a small window
		apb(1'b1, UDRT_IDX_MODE, 8'h05);
		apb(1'b1, UDRT_IDX_COUNT, 8'h00);
		repeat (40) @(posedge pclk);
		apb(1'b0, UDRT_IDX_COUNT, 8'h00);
		cmp1(rd >= 8'h09 && rd <= 8'h0c, 1'b1);
		sub_mode <= 1'b1;
		apb(1'b1, UDRT_IDX_MODE, 8'h05);
		apb(1'b1, UDRT_IDX_COUNT, 8'h30);
		repeat (20) @(posedge pclk);
		rdc(UDRT_IDX_COUNT, 8'h30);
		apb(1'b1, UDRT_IDX_MODE, 8'h06);
		for (int h = 0; h < 2; h++) begin
			halt_mode <= h[0];
			subclk_div4 <= 1'b1;
			repeat (8) @(posedge pclk);
			subclk_div4 <= 1'b0;
			repeat (8) @(posedge pclk);
			rdc(UDRT_IDX_COUNT, 8'h31);
		end
		halt_mode <= 1'b0;
		sub_mode <= 1'b0;
		apb(1'b1, UDRT_IDX_MODE, 8'h07);
		apb(1'b1, UDRT_IDX_COUNT, 8'h40);
		apb(1'b1, UDRT_IDX_CLKSTOP, 8'hfd);
		rdc(UDRT_IDX_CLKSTOP, 8'hfd);
		pulse(1);
		rdc(UDRT_IDX_COUNT, 8'h40);
		apb(1'b1, UDRT_IDX_CLKSTOP, 8'hff);
		pulse(1);
		rdc(UDRT_IDX_COUNT, 8'h41);
		apb(1'b0, 16'h0000, 8'h00);
		cmp1(er, 1'b1);
		summarize();
	end
endmodule // udrt_timer_tb
